// *** core/mcd_decoder.sv ***
// How it works
// - top nibble selects bit clear/set/toggle/skip
// - 1110 0xxx branches on flags, 1/2 cycles
// - call is two words, s selects fast
// - absolute jump is two words, two cycles
// - lone 1111 word executes as no-operation
// - single-word pc change or true test adds flush
// - 0x0006 pops, 0x0005 pushes stack
// - interrupt return re-enables, s restores fast
// - standby word updates watchdog and powerdown flags
// - literal add updates all five flags
// - literal subtract: literal minus accumulator
// - or/and/xor update zero and negative only
// - bank load writes low bank nibble
// - load and multiply change no flags
// - pointer load: two words, 12-bit literal
// - table reads 10xx, four pointer variants
// - table writes 11xx, four pointer variants
// - return with literal loads accumulator, returns
// - bit ops on ports use pin levels
// - bit op on timer clears prescaler if assigned
// - access bit 0 access bank, 1 bank
// - destination bit 0 accumulator, 1 file
//
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module mcd_decoder
   import mcd_pkg::*;
#(
   parameter int PORT_CNT = 5 // number of i/o port addresses
) (
   input  wire logic        sys_clk_i,      // core clock
   input  wire logic        arst_n_i,       // async reset, low
   input  wire logic [15:0] instr_i,        // fetched word
   input  wire logic        instr_valid_i,  // word present
   input  wire logic        flag_c_i,       // carry flag
   input  wire logic        flag_z_i,       // zero flag
   input  wire logic        flag_ov_i,      // overflow flag
   input  wire logic        flag_n_i,       // negative flag
   input  wire logic        skip_bit_i,     // tested bit value
   input  wire logic        presc_assign_i, // prescaler assigned
   output logic             ctrl_valid_o,   // ctrl_o valid
   output mcd_ctrl_s        ctrl_o,         // decoded controls
   input  wire logic        hsel_i,         // ahb select
   input  wire logic [31:0] haddr_i,        // ahb address
   input  wire logic [1:0]  htrans_i,       // ahb transfer
   input  wire logic        hwrite_i,       // ahb write
   input  wire logic [2:0]  hsize_i,        // ahb size
   input  wire logic [31:0] hwdata_i,       // ahb write data
   input  wire logic        hready_i,       // ahb bus ready
   output logic [31:0]      hrdata_o,       // ahb read data
   output logic             hreadyout_o,    // ahb slave ready
   output logic             hresp_o         // ahb response
);
   // ------------------------------------------------------------
   // elaboration check
   // ------------------------------------------------------------
   if (PORT_CNT < 1 || PORT_CNT > 256) begin : g_bad_ports
      $error("PORT_CNT must be 1 to 256");
   end

   // window of port addresses
   localparam logic [11:0] PORT_SPAN = 12'(PORT_CNT); // port range size

   // ------------------------------------------------------------
   // all state in one struct
   // ------------------------------------------------------------
   typedef struct packed {
      mcd_state_e  st;         // fetch sequencing state
      logic [15:0] first;      // held first word of long forms
      mcd_ctrl_s   ctrl;       // registered decode
      logic        ctrl_valid; // one cycle per issued step
      logic [3:0]  bank_select_pointer;        // local copy of bank pointer
      logic [11:0] timer_addr; // timer register address
      logic [11:0] port_base;  // first port address
      logic        wr_pend;    // ahb write in data phase
      logic [7:0]  wr_addr;    // its address
      logic [31:0] rdata;      // ahb read data
   } mcd_regs_s;

   // q is the only register
   mcd_regs_s q;      // registered state
   mcd_regs_s next_q; // next state

   logic [15:0] w;       // current word
   logic        cond;    // branch flag value
   logic        bit_mod; // set, clear or toggle
   logic        in_port; // address falls in port range
   mcd_ctrl_s   c;       // decode of this cycle

   // ------------------------------------------------------------
   // decode and bus logic
   // ------------------------------------------------------------
   // one process builds the whole next state
   always_comb begin
      next_q = q;
      next_q.ctrl_valid = 1'b0;
      w = instr_i;
      c = '0;
      c.op = OP_NOP;
      c.raw = w;
      c.bit_num = w[11:9];
      c.access = w[8];
      c.dest_file = w[9];
      c.literal = w[7:0];
      // access bank maps low page and top page
      if (w[8]) begin
         c.faddr = {q.bank_select_pointer, w[7:0]};
      end else if (w[7:0] < ACC_SPLIT) begin
         c.faddr = {4'h0, w[7:0]};
      end else begin
         c.faddr = {4'hf, w[7:0]};
      end
      // bit 8 inverts the flag test
      unique case (w[10:9])
         2'h0:    cond = flag_z_i;
         2'h1:    cond = flag_c_i;
         2'h2:    cond = flag_ov_i;
         default: cond = flag_n_i;
      endcase
      bit_mod = 1'b0;
      // pin reads only inside window
      in_port = (c.faddr >= q.port_base) &&
                (c.faddr - q.port_base < PORT_SPAN);

      // a stall holds all sequencing
      if (instr_valid_i) begin
         unique case (q.st)
            // word after a single-word pc change, a true skip or a table access is dropped
            ST_FLUSH: begin
               next_q.ctrl = c;
               next_q.ctrl.op = OP_NOP;
               next_q.ctrl.flag_mask = '0;
               next_q.ctrl_valid = 1'b1;
               next_q.st = ST_RUN;
            end
            // second word of a long form
            ST_OPERAND: begin
               c.raw = q.first;
               c.literal = q.first[7:0];
               next_q.st = ST_RUN;
               next_q.ctrl_valid = 1'b1;
               // pointer load decoded first
               if (w[15:12] != NIB_EXT) begin
                  c.op = OP_NOP; // broken pair, word lost
               end else if (q.first[11:9] == LONG_PTR && !q.first[8]) begin
                  c.op = OP_PTR_LOAD;
                  c.ptr_sel = q.first[5:4];
                  c.target = {8'h00, q.first[3:0], w[7:0]};
               end else begin
                  c.op = (q.first[10:8] == LONG_JMP) ? OP_JUMP_ABS
                                                      : OP_CALL;
                  c.target = {w[11:0], q.first[7:0]};
                  c.fast = (c.op == OP_CALL) & q.first[8];
                  c.pc_load = 1'b1;
               end
               next_q.ctrl = c;
            end
            default: begin
               unique case (w[15:12])
                  NIB_BCLR: c.op = OP_BIT_CLR;
                  NIB_BSET: c.op = OP_BIT_SET;
                  NIB_BTGL: c.op = OP_BIT_TGL;
                  NIB_SKPC: begin
                     c.op = OP_SKIP_CLR;
                     if (!skip_bit_i) begin
                        next_q.st = ST_FLUSH;
                     end
                  end
                  NIB_SKPS: begin
                     c.op = OP_SKIP_SET;
                     if (skip_bit_i) begin
                        next_q.st = ST_FLUSH;
                     end
                  end
                  NIB_REL: begin
                     c.op = w[11] ? OP_CALL_REL : OP_JUMP_REL;
                     c.target = {{9{w[10]}}, w[10:0]};
                     c.pc_load = 1'b1;
                     next_q.st = ST_FLUSH;
                  end
                  NIB_CTRL: begin
                     if (!w[11]) begin
                        c.op = OP_BRANCH;
                        c.target = {{12{w[7]}}, w[7:0]};
                        if (cond ^ w[8]) begin
                           c.pc_load = 1'b1;
                           next_q.st = ST_FLUSH;
                        end
                     end else if (w[11:9] == LONG_CALL ||
                                  w[10:8] == LONG_JMP ||
                                  (w[11:9] == LONG_PTR && !w[8])) begin
                        // hold word, wait for operand
                        next_q.first = w;
                        next_q.st = ST_OPERAND;
                     end else begin
                        c.op = OP_FILE;
                     end
                  end
                  NIB_EXT: c.op = OP_NOP;
                  NIB_LIT: begin
                     unique case (w[11:8])
                        LIT_ADD: begin
                           c.op = OP_LIT_ADD;
                           c.flag_mask = FL_ARITH;
                        end
                        LIT_SUB: begin
                           c.op = OP_LIT_SUB;
                           c.flag_mask = FL_ARITH;
                        end
                        LIT_OR: begin
                           c.op = OP_LIT_OR;
                           c.flag_mask = FL_ZN;
                        end
                        LIT_AND: begin
                           c.op = OP_LIT_AND;
                           c.flag_mask = FL_ZN;
                        end
                        LIT_XOR: begin
                           c.op = OP_LIT_XOR;
                           c.flag_mask = FL_ZN;
                        end
                        LIT_LOAD: c.op = OP_LIT_LOAD;
                        LIT_MUL:  c.op = OP_LIT_MUL;
                        LIT_RET: begin
                           c.op = OP_RET_LIT;
                           c.pc_load = 1'b1;
                           next_q.st = ST_FLUSH;
                        end
                        LIT_BANK: begin
                           if (w[7:4] == 4'h0) begin
                              c.op = OP_BANK_LOAD;
                              next_q.bank_select_pointer = w[3:0];
                           end else begin
                              c.op = OP_FILE;
                           end
                        end
                        LIT_MISC: begin
                           if (w[7:0] == W_SLEEP) begin
                              c.op = OP_SLEEP;
                              c.wdt_flag = 1'b1;
                              c.pd_flag = 1'b0;
                           end else if (w[7:0] == W_PUSH) begin
                              c.op = OP_PUSH;
                           end else if (w[7:0] == W_POP) begin
                              c.op = OP_POP;
                           end else if (w[7:1] == W_IRET) begin
                              c.op = OP_IRET;
                              c.fast = w[0];
                              c.pc_load = 1'b1;
                              next_q.st = ST_FLUSH;
                           end else if (w[7:1] == W_RET) begin
                              c.op = OP_RETURN;
                              c.fast = w[0];
                              c.pc_load = 1'b1;
                              next_q.st = ST_FLUSH;
                           end else if (w[7:2] == W_TABLE_READ_OP) begin
                              c.op = OP_TBL_RD;
                              c.tbl_mode = w[1:0];
                              next_q.st = ST_FLUSH;
                           end else if (w[7:2] == W_TBLWR) begin
                              c.op = OP_TBL_WR;
                              c.tbl_mode = w[1:0];
                              next_q.st = ST_FLUSH;
                           end else if (w[7:0] == 8'h00) begin
                              c.op = OP_NOP;
                           end else begin
                              c.op = OP_FILE; // datapath reads raw
                           end
                        end
                        default: c.op = OP_FILE;
                     endcase
                  end
                  default: c.op = OP_FILE;
               endcase
               // only modify ops read pins
               bit_mod = (c.op == OP_BIT_CLR) || (c.op == OP_BIT_SET) ||
                         (c.op == OP_BIT_TGL);
               c.use_pins = bit_mod && in_port;
               c.clr_presc = bit_mod && presc_assign_i &&
                             (c.faddr == q.timer_addr);
               // first word of a long form issues nothing yet
               if (next_q.st != ST_OPERAND) begin
                  next_q.ctrl = c;
                  next_q.ctrl_valid = 1'b1;
               end
            end
         endcase
      end

      // status register is read only
      // ahb data phase: write lands from the held address
      if (q.wr_pend) begin
         if (q.wr_addr == ADDR_TIMER) begin
            next_q.timer_addr = hwdata_i[11:0];
         end else if (q.wr_addr == ADDR_PORT) begin
            next_q.port_base = hwdata_i[11:0];
         end
      end
      // ahb address phase; slave never stalls
      next_q.wr_pend = 1'b0;
      if (hsel_i && hready_i && htrans_i[1]) begin
         next_q.wr_pend = hwrite_i && (hsize_i == HSIZE_WORD);
         next_q.wr_addr = haddr_i[7:0];
         if (!hwrite_i) begin
            unique case (haddr_i[7:0])
               ADDR_TIMER: next_q.rdata = {20'h00000, q.timer_addr};
               ADDR_PORT:  next_q.rdata = {20'h00000, q.port_base};
               ADDR_STAT:  next_q.rdata = {20'h00000, q.bank_select_pointer, q.st,
                                           q.ctrl_valid, q.ctrl.op};
               default:    next_q.rdata = 32'h00000000; // unmapped
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   // reset holds a no-operation decode with no valid strobe
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q <= '0;
         // default address map
         q.timer_addr <= RST_TIMER;
         q.port_base <= RST_PORT;
      end else begin
         q <= next_q;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign ctrl_o = q.ctrl;
   assign ctrl_valid_o = q.ctrl_valid;
   assign hrdata_o = q.rdata;
   // bus never waits, never errs
   assign hreadyout_o = 1'b1; // zero wait states
   assign hresp_o = 1'b0;     // always okay
endmodule
`default_nettype wire

// *** core/mcd_pkg.sv ***
`default_nettype none
package mcd_pkg;
   // ------------------------------------------------------------
   // register map (byte addresses, one word each)
   // ------------------------------------------------------------
   localparam logic [7:0]  ADDR_TIMER = 8'h00; // timer register address
   localparam logic [7:0]  ADDR_PORT  = 8'h04; // first i/o port address
   localparam logic [7:0]  ADDR_STAT  = 8'h08; // decoder state, read only
   localparam logic [11:0] RST_TIMER  = 12'hfd6; // timer address reset
   localparam logic [11:0] RST_PORT   = 12'hf8d; // port base reset
   localparam logic [2:0]  HSIZE_WORD = 3'h2; // only whole-word writes
   // ------------------------------------------------------------
   // opcode fields
   // ------------------------------------------------------------
   localparam logic [3:0] NIB_BCLR = 4'h9; // bit clear
   localparam logic [3:0] NIB_BSET = 4'h8; // bit set
   localparam logic [3:0] NIB_BTGL = 4'h7; // bit toggle
   localparam logic [3:0] NIB_SKPC = 4'hb; // skip if clear
   localparam logic [3:0] NIB_SKPS = 4'ha; // skip if set
   localparam logic [3:0] NIB_REL  = 4'hd; // relative jump / call
   localparam logic [3:0] NIB_CTRL = 4'he; // branches, long forms
   localparam logic [3:0] NIB_EXT  = 4'hf; // second word / no-op
   localparam logic [3:0] NIB_LIT  = 4'h0; // literal and misc group
   localparam logic [3:0] LIT_ADD  = 4'hf; // literal add
   localparam logic [3:0] LIT_SUB  = 4'h8; // literal subtract
   localparam logic [3:0] LIT_OR   = 4'h9; // literal or
   localparam logic [3:0] LIT_AND  = 4'hb; // literal and
   localparam logic [3:0] LIT_XOR  = 4'ha; // literal xor
   localparam logic [3:0] LIT_LOAD = 4'he; // accumulator load
   localparam logic [3:0] LIT_MUL  = 4'hd; // literal multiply
   localparam logic [3:0] LIT_RET  = 4'hc; // return with literal
   localparam logic [3:0] LIT_BANK = 4'h1; // bank pointer load
   localparam logic [3:0] LIT_MISC = 4'h0; // single-word specials
   localparam logic [2:0] LONG_CALL = 3'h6; // 110s call first word
   localparam logic [2:0] LONG_JMP  = 3'h7; // absolute jump
   localparam logic [2:0] LONG_PTR  = 3'h7; // pointer load, w[11:9]
   localparam logic [7:0] W_SLEEP = 8'h03; // standby
   localparam logic [7:0] W_PUSH  = 8'h05; // push return stack
   localparam logic [7:0] W_POP   = 8'h06; // discard stack top
   localparam logic [6:0] W_IRET  = 7'h08; // 0001 000s
   localparam logic [6:0] W_RET   = 7'h09; // 0001 001s
   localparam logic [5:0] W_TABLE_READ_OP = 6'h02; // 0000 10xx
   localparam logic [5:0] W_TBLWR = 6'h03; // 0000 11xx
   localparam logic [7:0] ACC_SPLIT = 8'h60; // access bank low/high split
   localparam logic [4:0] FL_ARITH = 5'h1f; // n ov z dc c
   localparam logic [4:0] FL_ZN    = 5'h14; // n z only

   typedef enum logic [1:0] {ST_RUN, ST_OPERAND, ST_FLUSH} mcd_state_e;

   typedef enum logic [4:0] {
      OP_NOP, OP_BIT_CLR, OP_BIT_SET, OP_BIT_TGL, OP_SKIP_CLR, OP_SKIP_SET,
      OP_BRANCH, OP_JUMP_REL, OP_CALL_REL, OP_CALL, OP_JUMP_ABS, OP_PUSH,
      OP_POP, OP_IRET, OP_RETURN, OP_SLEEP, OP_LIT_ADD, OP_LIT_SUB,
      OP_LIT_OR, OP_LIT_AND, OP_LIT_XOR, OP_LIT_LOAD, OP_LIT_MUL,
      OP_RET_LIT, OP_BANK_LOAD, OP_PTR_LOAD, OP_TBL_RD, OP_TBL_WR, OP_FILE
   } mcd_op_e;

   typedef struct packed {
      mcd_op_e     op;        // decoded action
      logic [15:0] raw;       // word as fetched (first word if long)
      logic [2:0]  bit_num;   // bit number of bit operations
      logic        access;    // access select bit
      logic        dest_file; // 1: result back to file register
      logic [11:0] faddr;     // resolved file address
      logic [7:0]  literal;   // 8-bit literal
      logic [19:0] target;    // jump target, offset or pointer value
      logic        fast;      // fast save / restore
      logic [1:0]  ptr_sel;   // indirect pointer select
      logic [1:0]  tbl_mode;  // table pointer update variant
      logic [4:0]  flag_mask; // n ov z dc c updated
      logic        pc_load;   // program counter changes
      logic        use_pins;  // modify pin levels, not latch
      logic        clr_presc; // clear timer prescaler
      logic        wdt_flag;  // new watchdog-expired flag value
      logic        pd_flag;   // new power-down flag value
   } mcd_ctrl_s;
endpackage
`default_nettype wire

// *** dv/mcd_decoder_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module mcd_decoder_props
   import mcd_pkg::*;
(
   input wire logic        sys_clk_i,      // core clock
   input wire logic        arst_n_i,       // async reset, low
   input wire logic [15:0] instr_i,        // fetched word
   input wire logic        instr_valid_i,  // word present
   input wire logic        presc_assign_i, // prescaler assigned
   input wire logic        ctrl_valid_o,   // step issued
   input wire mcd_ctrl_s   ctrl_o          // decoded controls
);
   // ---------------------------
   // one clock, one reset
   // ---------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);
   chk_add_decode: assert property (ctrl_valid_o && ctrl_o.op == OP_LIT_ADD |->
      ctrl_o.flag_mask == FL_ARITH && ctrl_o.literal == $past(instr_i[7:0]))
      else $error("literal add decoded wrong");
   chk_zn_only: assert property (ctrl_valid_o &&
      ctrl_o.op inside {OP_LIT_OR, OP_LIT_AND, OP_LIT_XOR} |-> ctrl_o.flag_mask == FL_ZN)
      else $error("logic literal flag mask wrong");
   chk_no_flags: assert property (ctrl_valid_o &&
      ctrl_o.op inside {OP_LIT_LOAD, OP_LIT_MUL, OP_BANK_LOAD, OP_PUSH, OP_POP, OP_BIT_SET,
      OP_BIT_CLR, OP_BIT_TGL} |-> ctrl_o.flag_mask == 5'h00) else $error("flags touched");
   chk_long_word2: assert property (ctrl_valid_o &&
      ctrl_o.op inside {OP_CALL, OP_JUMP_ABS} |-> $past(instr_i[15:12]) == NIB_EXT
      && ctrl_o.target[19:8] == $past(instr_i[11:0])) else $error("long target wrong");
   // a taken single-word change of flow, or a table access, must swallow the word fetched behind it
   chk_flush_next: assert property (ctrl_valid_o && instr_valid_i &&
      (ctrl_o.op == OP_BRANCH && ctrl_o.pc_load || ctrl_o.op inside {OP_JUMP_REL,
      OP_CALL_REL, OP_RETURN, OP_IRET, OP_RET_LIT, OP_TBL_RD, OP_TBL_WR})
      |=> ctrl_valid_o && ctrl_o.op == OP_NOP) else $error("no flush step");
   chk_sleep_flags: assert property (ctrl_valid_o && ctrl_o.op == OP_SLEEP |->
      ctrl_o.wdt_flag && !ctrl_o.pd_flag) else $error("standby flags wrong");
   chk_reset_idle: assert property ($rose(arst_n_i) |->
      !ctrl_valid_o && ctrl_o.op == OP_NOP) else $error("not idle after reset");
   chk_valid_cause: assert property (ctrl_valid_o |-> $past(instr_valid_i))
      else $error("step without a word");
   chk_presc_clear: assert property (ctrl_valid_o && ctrl_o.clr_presc |->
      $past(presc_assign_i) && ctrl_o.op inside {OP_BIT_CLR, OP_BIT_SET, OP_BIT_TGL})
      else $error("prescaler clear without cause");
   chk_tbl_mode: assert property (ctrl_valid_o &&
      ctrl_o.op inside {OP_TBL_RD, OP_TBL_WR} |-> ctrl_o.tbl_mode == $past(instr_i[1:0]))
      else $error("table pointer variant wrong");
endmodule
`default_nettype wire

// *** dv/mcd_fetch.sv ***
`timescale 1ns/10ps
`default_nettype none
module mcd_fetch (
   input  wire logic        clk_i,   // core clock
   output logic [15:0]      word_o,  // fetched word
   output logic             valid_o  // word present
);
   // ---------------------------
   // fetch stream, one word per edge
   // ---------------------------
   initial begin
      word_o = 16'h0000;
      valid_o = 1'b0;
   end
   task automatic put(input logic [15:0] w);
      @(posedge clk_i);
      word_o <= w;
      valid_o <= 1'b1;
   endtask
   // stall: invert so a stale word is never mistaken for fresh data
   task automatic idle();
      @(posedge clk_i);
      word_o <= ~word_o;
      valid_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

// *** dv/tb_mcd_decoder.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_mcd_decoder
   import mcd_pkg::*;
;
   logic        sys_clk_i = 1'b0;  // core clock
   logic        arst_n_i = 1'b0;   // async reset, low
   logic [15:0] instr_w;           // word from fetch model
   logic        ivalid_w;          // word present
   logic        flag_z = 1'b0;     // zero flag
   logic        flag_c = 1'b0, flag_ov = 1'b0, flag_n = 1'b0, skip_bit = 1'b0; // flags
   logic        presc = 1'b0;      // prescaler assigned
   logic [31:0] haddr = '0;        // bus address
   logic [1:0]  htrans = 2'h0;     // bus transfer
   logic        hwrite = 1'b0;     // bus write
   logic [2:0]  hsize = HSIZE_WORD; // bus size
   logic [31:0] hwdata = '0;       // bus write data
   logic [31:0] hrdata_o;          // bus read data
   logic        hreadyout_o;       // slave ready
   logic        hresp_o;           // slave response
   logic        ctrl_valid_o;      // step issued
   mcd_ctrl_s   ctrl_o;            // decoded controls
   int          mismatches = 0;    // failed compares
   int          checked = 0;       // compares made
   mcd_fetch mcd_fetch_inst (.clk_i(sys_clk_i), .word_o(instr_w), .valid_o(ivalid_w));
   mcd_decoder mcd_decoder_inst (.sys_clk_i, .arst_n_i, .instr_i(instr_w),
      .instr_valid_i(ivalid_w), .flag_c_i(flag_c), .flag_z_i(flag_z), .flag_ov_i(flag_ov),
      .flag_n_i(flag_n), .skip_bit_i(skip_bit), .presc_assign_i(presc), .ctrl_valid_o, .ctrl_o,
      .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
      .hwdata_i(hwdata), .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o);
   initial forever #5 sys_clk_i = ~sys_clk_i;
   // ---------------------------
   // compare, bus cycle, single word
   // ---------------------------
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge sys_clk_i);
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
      rd = hrdata_o;
      cmp(32'(hresp_o), 32'h0);
   endtask
   task automatic one(input logic [15:0] w, input mcd_op_e op, input logic [4:0] fm);
      mcd_fetch_inst.put(w);
      mcd_fetch_inst.idle();
      #1;
      cmp(32'(ctrl_valid_o), 32'h1);
      cmp(32'(ctrl_o.op), 32'(op));
      cmp(32'(ctrl_o.flag_mask), 32'(fm));
   endtask
   task automatic bit_ops();
      presc <= 1'b1;
      flag_z <= 1'b1;
      one(16'h82d6, OP_BIT_SET, 5'h00);
      cmp(32'(ctrl_o.faddr), 32'hfd6);
      cmp(32'(ctrl_o.clr_presc), 32'h1);
      one(16'h908d, OP_BIT_CLR, 5'h00);
      cmp(32'(ctrl_o.use_pins), 32'h1);
   endtask
   task automatic lit_table();
      logic [15:0] w [11];
      mcd_op_e     o [11];
      w = '{16'h0f15, 16'h0820, 16'h0933, 16'h0b44, 16'h0a55, 16'h0e66, 16'h0d77,
            16'h0105, 16'h0005, 16'h0006, 16'h0003};
      o = '{OP_LIT_ADD, OP_LIT_SUB, OP_LIT_OR, OP_LIT_AND, OP_LIT_XOR, OP_LIT_LOAD,
            OP_LIT_MUL, OP_BANK_LOAD, OP_PUSH, OP_POP, OP_SLEEP};
      for (int i = 0; i < 11; i++) begin
         one(w[i], o[i], i < 2 ? FL_ARITH : (i < 5 ? FL_ZN : 5'h00));
      end
   endtask
   // each of these must be followed by one swallowed word
   task automatic flush_table();
      logic [15:0] w [7];
      mcd_op_e     o [7];
      w = '{16'he005, 16'hd010, 16'h0012, 16'h0011, 16'h0c42, 16'h0009, 16'h000e};
      o = '{OP_BRANCH, OP_JUMP_REL, OP_RETURN, OP_IRET, OP_RET_LIT, OP_TBL_RD, OP_TBL_WR};
      for (int i = 0; i < 7; i++) begin
         mcd_fetch_inst.put(w[i]);
         mcd_fetch_inst.put(16'h0f01);
         #1;
         cmp(32'(ctrl_o.op), 32'(o[i]));
         mcd_fetch_inst.idle();
         #1;
         cmp(32'(ctrl_o.op), 32'(OP_NOP));
      end
      mcd_fetch_inst.put(16'he105);
      one(16'h0f01, OP_LIT_ADD, FL_ARITH);
   endtask
   task automatic long_forms();
      mcd_fetch_inst.put(16'hec12);
      one(16'hf345, OP_CALL, 5'h00);
      cmp(32'(ctrl_o.target), 32'h34512);
      mcd_fetch_inst.put(16'hef12);
      one(16'hf678, OP_JUMP_ABS, 5'h00);
      cmp(32'(ctrl_o.target), 32'h67812);
      mcd_fetch_inst.put(16'hee15);
      one(16'hf0ab, OP_PTR_LOAD, 5'h00);
      cmp(32'(ctrl_o.target), 32'h005ab);
      mcd_fetch_inst.put(16'hef12);
      one(16'h0f01, OP_NOP, 5'h00);
      one(16'hf123, OP_NOP, 5'h00);
   endtask
   task automatic skip_branch();
      skip_bit <= 1'b1;
      flag_c <= 1'b1;
      flag_ov <= 1'b1;
      flag_n <= 1'b1;
      one(16'hb312, OP_SKIP_CLR, 5'h00);
      cmp(32'(ctrl_o.faddr), 32'h512);
      mcd_fetch_inst.put(16'ha312);
      mcd_fetch_inst.put(16'hef12);
      #1;
      cmp(32'(ctrl_o.op), 32'(OP_SKIP_SET));
      one(16'hf678, OP_NOP, 5'h00);
      mcd_fetch_inst.put(16'he203);
      one(16'h0e01, OP_NOP, 5'h00);
      mcd_fetch_inst.put(16'he503);
      one(16'h0e01, OP_LIT_LOAD, 5'h00);
      mcd_fetch_inst.put(16'he603);
      one(16'h0e01, OP_NOP, 5'h00);
      one(16'h2612, OP_FILE, 5'h00);
      cmp(32'(ctrl_o.dest_file), 32'h1);
   endtask
   task automatic regs();
      logic [31:0] rd;
      ahb(1'b0, 32'h0, 32'h0, rd);
      cmp(rd, 32'(RST_TIMER));
      ahb(1'b0, 32'h4, 32'h0, rd);
      cmp(rd, 32'(RST_PORT));
      ahb(1'b0, 32'h8, 32'h0, rd);
      cmp(32'(rd[11:8]), 32'h5);
      ahb(1'b1, 32'h0, 32'h0a5, rd);
      ahb(1'b0, 32'h0, 32'h0, rd);
      cmp(rd, 32'h0a5);
      ahb(1'b0, 32'hc, 32'h0, rd);
      cmp(rd, 32'h0);
   endtask
   task automatic end_of_test();
      if (mismatches == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      bit_ops();
      lit_table();
      flush_table();
      long_forms();
      skip_branch();
      regs();
      end_of_test();
   end
   // watchdog: the sequence needs about a hundred cycles
   initial begin
      #20000;
      mismatches++;
      end_of_test();
   end
endmodule
bind mcd_decoder mcd_decoder_props mcd_decoder_props_inst (.sys_clk_i, .arst_n_i, .instr_i,
   .instr_valid_i, .presc_assign_i, .ctrl_valid_o, .ctrl_o);
`default_nettype wire
